// [sim/source_model.sv]
// Peripheral and trap source model driving request levels
`timescale 1ns/10ps
`default_nettype none
module source_model (
	input  wire logic        mclk,
	input  wire logic [24:0] want,
	output logic      [24:0] lines
);
	// Levels change just after a clock edge, as a peripheral would
	always_ff @(posedge mclk) lines <= want;
endmodule : source_model
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the vector map and pending flag bank
`timescale 1ns/10ps
`default_nettype none
module tb import vector_map_pkg::*; ;
	logic        mclk = 1'h0, reset = 1'h1, awv = 1'h0, wv = 1'h0, bRdy = 1'h0, arv = 1'h0, rRdy = 1'h0;
	logic [7:0]  aw = 8'h00, ar = 8'h00, trapAct;
	logic [31:0] wd = 32'h0, rdata;
	logic [3:0]  ws = 4'h0;
	logic [24:0] want = 25'h0, src;
	logic [15:0] flagReq = 16'h0;
	logic [22:0] srcAct;
	logic        awRdy, wRdy, bv, arRdy, rv;
	logic [1:0]  bresp, rresp;
	int          failures = 0, n_compared = 0, cycles = 0;
	int          vecs[27] = '{54, 55, 56, 57, 58, 59, 60, 61, 62, 63, 64, 65, 66, 67, 68, 69, 70, 72, 73, 74, 75,
		76, 77, 78, 79, 80, 125};
	always #5 mclk = ~mclk;
	source_model i_src (.mclk(mclk), .want(want), .lines(src));
	interrupt_vector_and_flag_map i_dut (.mclk(mclk), .reset(reset), .timerSixReq(src[0]), .timerSevenReq(src[1]),
		.second_twowire_slave_event(src[2]), .second_twowire_master_event(src[3]), .timerEightReq(src[4]),
		.timerNineReq(src[5]), .externalThreeReq(src[6]), .externalFourReq(src[7]),
		.second_can_receive_ready(src[8]), .secondCanEvent(src[9]), .codec_port_error(src[10]),
		.codec_port_done(src[11]), .dmaFiveReq(src[12]), .first_uart_error(src[13]), .second_uart_error(src[14]),
		.dmaSixReq(src[15]), .dmaSevenReq(src[16]), .first_can_transmit_request(src[17]),
		.second_can_transmit_request(src[18]), .dmaFourReq(src[19]), .oscFailTrap(src[20]),
		.addressErrorTrap(src[21]), .stackErrorTrap(src[22]), .mathErrorTrap(src[23]), .dmaErrorTrap(src[24]),
		.flagSourceReq(flagReq), .sourceActive_q(srcAct), .trapActive_q(trapAct), .s_axi_awaddr(aw),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awRdy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wRdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bRdy),
		.s_axi_araddr(ar), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arRdy), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rRdy));
	task automatic report_and_stop;
		$display("Compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		@(posedge mclk);
		aw <= a;
		wd <= d;
		ws <= s;
		awv <= 1'h1;
		wv <= 1'h1;
		bRdy <= 1'h1;
		do begin
			@(posedge mclk);
			if (awRdy === 1'h1)
				awv <= 1'h0;
			if (wRdy === 1'h1)
				wv <= 1'h0;
		end while (awv && awRdy !== 1'h1 || wv && wRdy !== 1'h1);
		do @(posedge mclk); while (bv !== 1'h1);
		r = bresp;
		bRdy <= 1'h0;
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] expResp);
		@(posedge mclk);
		ar <= a;
		arv <= 1'h1;
		rRdy <= 1'h1;
		do @(posedge mclk); while (arRdy !== 1'h1);
		arv <= 1'h0;
		do @(posedge mclk); while (rv !== 1'h1);
		rRdy <= 1'h0;
		chk(rdata, exp);
		chk(32'(rresp), 32'(expResp));
	endtask : rdchk
	function automatic logic [31:0] lookup(input int n, input logic trap, input logic alt);
		logic conn;
		conn = trap ? (n >= 1 && n <= 5) : (n >= 54 && n <= 64 || n inside {67, 68, 69, 73, 74} || n >= 76 && n <= 79);
		return {conn, trap ? 7'h00 : 7'(n - 8), 24'h000004 + 24'(2 * n) + (alt ? 24'h000100 : 24'h000000)};
	endfunction : lookup
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			report_and_stop();
		end
	end
	initial begin
		logic [1:0] r;
		int         n;
		repeat (4) @(posedge mclk);
		reset <= 1'h0;
		rdchk(PendingFlagsAddr, 32'h0, RespOkay);
		flagReq <= 16'hFFFF;
		repeat (5) @(posedge mclk);
		flagReq <= 16'h0000;
		rdchk(PendingFlagsAddr, 32'h0000FFFB, RespOkay);
		// Lane 0 clears bits written as zero, lane 1 is left alone
		wr(PendingFlagsAddr, 32'h000000F4, 4'h1, r);
		chk(32'(r), 32'(RespOkay));
		rdchk(PendingFlagsAddr, 32'h0000FFF0, RespOkay);
		// A source still requesting keeps its flag against a clear
		flagReq <= 16'h0001;
		repeat (4) @(posedge mclk);
		wr(PendingFlagsAddr, 32'h00000000, 4'h3, r);
		flagReq <= 16'h0000;
		repeat (3) @(posedge mclk);
		rdchk(PendingFlagsAddr, 32'h00000001, RespOkay);
		wr(PendingFlagsAddr, 32'h00000000, 4'h3, r);
		rdchk(PendingFlagsAddr, 32'h00000000, RespOkay);
		wr(8'h0C, 32'hFFFFFFFF, 4'hF, r);
		chk(32'(r), 32'(RespSlvErr));
		rdchk(8'h0C, 32'h0, RespSlvErr);
		for (int k = 0; k < 35; k++)
			for (int alt = 0; alt < 2; alt++) begin
				n = k < 8 ? k : vecs[k - 8];
				wr(LookupSelectAddr, {22'h0, alt[0], k < 8, 1'h0, 7'(n)}, 4'hF, r);
				chk(32'(r), 32'(RespOkay));
				repeat (2) @(posedge mclk);
				rdchk(LookupResultAddr, lookup(n, k < 8, alt[0]), RespOkay);
			end
		for (int i = 0; i < 20; i++) begin
			want <= {5'(1 << (i % 5)), 20'(1 << i)};
			repeat (6) @(posedge mclk);
			chk(32'(srcAct), 32'h1 << i);
			chk(32'(trapAct), 32'h2 << (i % 5));
		end
		report_and_stop();
	end
endmodule : tb
bind interrupt_vector_and_flag_map vector_map_props i_props (.*);
`default_nettype wire

// [sim/vector_map_props.sv]
// Checker for source routing, trap lines and register bus answers
`timescale 1ns/10ps
`default_nettype none
module vector_map_props
	import vector_map_pkg::*;
(
	input wire logic        mclk,
	input wire logic        reset,
	input wire logic        timerSixReq,
	input wire logic        second_can_receive_ready,
	input wire logic        codec_port_error,
	input wire logic        oscFailTrap,
	input wire logic [22:0] sourceActive_q,
	input wire logic [7:0]  trapActive_q,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp
);
	logic [2:0] age_q;
	logic       settled;
	// Pipeline history is trusted only four edges after reset
	always_ff @(posedge mclk) age_q <= reset ? 3'h0 : (age_q == 3'h4 ? age_q : age_q + 3'h1);
	assign settled = age_q == 3'h4;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	timer_route_a: assert property (settled |-> sourceActive_q[0] == $past(timerSixReq, 3))
		else $error("timer request not routed");
	can_route_a: assert property (settled |-> sourceActive_q[8] == $past(second_can_receive_ready, 3))
		else $error("receive ready not routed");
	codec_route_a: assert property (settled |-> sourceActive_q[10] == $past(codec_port_error, 3))
		else $error("codec error not routed");
	reserved_idle_a: assert property (sourceActive_q[22:20] == 3'h0)
		else $error("unconnected source active");
	osc_trap_a: assert property (settled |-> trapActive_q[1] == $past(oscFailTrap, 3))
		else $error("oscillator trap not routed");
	trap_reserved_a: assert property (trapActive_q[0] == 1'h0 && trapActive_q[7:6] == 2'h0)
		else $error("reserved trap active");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response held too long");
	cover property (s_axi_bvalid && s_axi_bresp == RespSlvErr);
	cover property (trapActive_q[1]);
	cover property (sourceActive_q[8]);
endmodule : vector_map_props
`default_nettype wire

// [verilog/interrupt_vector_and_flag_map.sv]
// Interrupt source routing, vector lookup and pending flag bank
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Vector address 4+2N, alternate +0x100, index N-8 for sources, 0 for traps
// - Timers, second two-wire, externals on 55..62
// - Second CAN receive/event 63/64, first/second CAN transmits 78/79
// - Codec 67/68, DMA 54/69/76/77, UART errors 73/74
// - Reserved vectors have no source connected
// - Eight trap vectors, sources 1 to 5
// - Unimplemented bits read zero, writes ignored
module interrupt_vector_and_flag_map
	import vector_map_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset,
	// Peripheral requests routed to vectors 54..79
	input  wire logic        timerSixReq,
	input  wire logic        timerSevenReq,
	input  wire logic        second_twowire_slave_event,
	input  wire logic        second_twowire_master_event,
	input  wire logic        timerEightReq,
	input  wire logic        timerNineReq,
	input  wire logic        externalThreeReq,
	input  wire logic        externalFourReq,
	input  wire logic        second_can_receive_ready,
	input  wire logic        secondCanEvent,
	input  wire logic        codec_port_error,
	input  wire logic        codec_port_done,
	input  wire logic        dmaFiveReq,
	input  wire logic        first_uart_error,
	input  wire logic        second_uart_error,
	input  wire logic        dmaSixReq,
	input  wire logic        dmaSevenReq,
	input  wire logic        first_can_transmit_request,
	input  wire logic        second_can_transmit_request,
	input  wire logic        dmaFourReq,
	// Trap sources
	input  wire logic        oscFailTrap,
	input  wire logic        addressErrorTrap,
	input  wire logic        stackErrorTrap,
	input  wire logic        mathErrorTrap,
	input  wire logic        dmaErrorTrap,
	// Sources of the pending flag bank, bit per flag
	input  wire logic [15:0] flagSourceReq,
	// Core-side vector request view
	output logic      [22:0] sourceActive_q,
	output logic      [7:0]  trapActive_q,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// ---------------------------------------------------------------
	// Source routing, index order follows VectorList
	// ---------------------------------------------------------------
	wire logic [22:0] srcRaw = {3'b000,
		dmaFourReq, second_can_transmit_request, first_can_transmit_request,
		dmaSevenReq, dmaSixReq, second_uart_error, first_uart_error,
		dmaFiveReq, codec_port_done, codec_port_error,
		secondCanEvent, second_can_receive_ready,
		externalFourReq, externalThreeReq, timerNineReq, timerEightReq,
		second_twowire_master_event, second_twowire_slave_event,
		timerSevenReq, timerSixReq};
	wire logic [7:0]  trapRaw = {2'b00, dmaErrorTrap, mathErrorTrap, stackErrorTrap,
		addressErrorTrap, oscFailTrap, 1'b0};
	logic [22:0] srcSync1_q;
	logic [22:0] srcSync2_q;
	logic [7:0]  trapSync1_q;
	logic [7:0]  trapSync2_q;
	logic [15:0] flagSync1_q;
	logic [15:0] flagSync2_q;
	always_ff @(posedge mclk) begin
		srcSync1_q  <= srcRaw;
		srcSync2_q  <= srcSync1_q;
		trapSync1_q <= trapRaw;
		trapSync2_q <= trapSync1_q;
		flagSync1_q <= flagSourceReq;
		flagSync2_q <= flagSync1_q;
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			sourceActive_q <= 23'h000000;
			trapActive_q   <= 8'h00;
		end else begin
			sourceActive_q <= srcSync2_q & SourceLive;
			trapActive_q   <= trapSync2_q & TrapLive;
		end
	end

	// ---------------------------------------------------------------
	// Write channel
	// ---------------------------------------------------------------
	logic        awHeld_q;
	logic [7:0]  awAddr_q;
	logic        wHeld_q;
	logic [31:0] wData_q;
	logic [3:0]  wStrb_q;
	logic [15:0] pendingFlags_q;
	logic [9:0]  lookupSel_q;
	wire logic   awTake   = s_axi_awvalid && s_axi_awready;
	wire logic   wTake    = s_axi_wvalid && s_axi_wready;
	wire logic   writeGo  = awHeld_q && wHeld_q && !s_axi_bvalid;
	wire logic   wrFlags  = writeGo && awAddr_q == PendingFlagsAddr;
	wire logic   wrSel    = writeGo && awAddr_q == LookupSelectAddr;
	wire logic   wrHit    = wrFlags || wrSel || awAddr_q == LookupResultAddr;
	wire logic [15:0] laneMask = {{8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
	// Clear only where software writes zero through an enabled lane
	wire logic [15:0] clearMask = wrFlags ? (laneMask & ~wData_q[15:0]) : 16'h0000;
	wire logic [15:0] flags_d  = ((pendingFlags_q & ~clearMask) | flagSync2_q)
		& PendingFlagsMask;
	always_ff @(posedge mclk) begin
		if (reset) begin
			awHeld_q      <= 1'b0;
			wHeld_q       <= 1'b0;
			awAddr_q      <= 8'h00;
			wData_q       <= 32'h00000000;
			wStrb_q       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RespOkay;
		end else begin
			s_axi_awready <= !awHeld_q && !awTake;
			s_axi_wready  <= !wHeld_q && !wTake;
			if (awTake) begin
				awHeld_q <= 1'b1;
				awAddr_q <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (wTake) begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (writeGo) begin
				awHeld_q     <= 1'b0;
				wHeld_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrHit ? RespOkay : RespSlvErr;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			pendingFlags_q <= PendingFlagsReset;
			lookupSel_q    <= 10'h000;
		end else begin
			pendingFlags_q <= flags_d;
			if (wrSel && wStrb_q[0]) begin
				lookupSel_q[7:0] <= {1'b0, wData_q[6:0]};
			end
			if (wrSel && wStrb_q[1]) begin
				lookupSel_q[9:8] <= wData_q[9:8];
			end
		end
	end

	// ---------------------------------------------------------------
	// Vector lookup
	// ---------------------------------------------------------------
	logic [23:0] lookupAddr;
	logic [6:0]  lookupIndex;
	logic        lookupLive;
	vector_address_calc u_calc (
		.mclk           (mclk),
		.reset          (reset),
		.vectorNum      (lookupSel_q[SelVecLsb +: 7]),
		.isTrap         (lookupSel_q[SelTrapBit]),
		.useAlternate   (lookupSel_q[SelAltBit]),
		.tableAddr_q    (lookupAddr),
		.requestIndex_q (lookupIndex),
		.connected_q    (lookupLive)
	);

	// ---------------------------------------------------------------
	// Read channel
	// ---------------------------------------------------------------
	wire logic [7:0] rdAddr = {s_axi_araddr[7:2], 2'b00};
	wire logic       arTake = s_axi_arvalid && s_axi_arready;
	wire logic       rdHit  = rdAddr == PendingFlagsAddr || rdAddr == LookupSelectAddr
		|| rdAddr == LookupResultAddr;
	wire logic [31:0] rdData =
		rdAddr == PendingFlagsAddr ? {16'h0000, pendingFlags_q & PendingFlagsMask} :
		rdAddr == LookupSelectAddr ? {22'h000000, lookupSel_q} :
		rdAddr == LookupResultAddr ? {lookupLive, lookupIndex, lookupAddr} :
		32'h00000000;
	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RespOkay;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !arTake;
			if (arTake) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rdData;
				s_axi_rresp  <= rdHit ? RespOkay : RespSlvErr;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : interrupt_vector_and_flag_map
`default_nettype wire

// [verilog/vector_address_calc.sv]
// Vector number to table address and request index lookup
`timescale 1ns/10ps
`default_nettype none
module vector_address_calc
	import vector_map_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic [6:0]  vectorNum,
	input  wire logic        isTrap,
	input  wire logic        useAlternate,
	output logic      [23:0] tableAddr_q,
	output logic      [6:0]  requestIndex_q,
	output logic             connected_q
);
	// ---------------------------------------------------------------
	// Address arithmetic
	// ---------------------------------------------------------------
	wire logic [23:0] primaryAddr   = PrimaryTableBase + {16'h0000, vectorNum, 1'b0};
	wire logic [23:0] alternateAddr = primaryAddr + AlternateTableOfs;
	wire logic [23:0] addr_d        = useAlternate ? alternateAddr : primaryAddr;
	wire logic [6:0]  index_d       = isTrap ? 7'h00 : vectorNum - RequestIndexOfs;
	logic             live;
	always_comb begin
		live = 1'b0;
		if (isTrap) begin
			live = (vectorNum < 7'd8) && TrapLive[vectorNum[2:0]];
		end else begin
			for (int i = 0; i < SourceCount; i++) begin
				if (SourceLive[i] && VectorList[i] == vectorNum) begin
					live = 1'b1;
				end
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			tableAddr_q    <= 24'h000000;
			requestIndex_q <= 7'h00;
			connected_q    <= 1'b0;
		end else begin
			tableAddr_q    <= addr_d;
			requestIndex_q <= index_d;
			connected_q    <= live;
		end
	end
endmodule : vector_address_calc
`default_nettype wire

// [verilog/vector_map_pkg.sv]
// Constants for the interrupt vector map and pending flag bank
package vector_map_pkg;
	// ---------------------------------------------------------------
	// Vector table layout
	// ---------------------------------------------------------------
	localparam logic [23:0] PrimaryTableBase   = 24'h000004;
	localparam logic [23:0] AlternateTableOfs  = 24'h000100;
	localparam logic [6:0]  RequestIndexOfs    = 7'h08;
	localparam int          VectorCount        = 126;
	localparam int          TrapCount          = 8;
	localparam int          SourceCount        = 23;
	// Peripheral source numbering (index into source request vector)
	localparam logic [6:0] VectorList [SourceCount] = '{
		7'd55, 7'd56, 7'd57, 7'd58, 7'd59, 7'd60, 7'd61, 7'd62,
		7'd63, 7'd64, 7'd67, 7'd68, 7'd69, 7'd73, 7'd74, 7'd76,
		7'd77, 7'd78, 7'd79, 7'd54, 7'd0, 7'd0, 7'd0};
	localparam logic [22:0] SourceLive         = 23'h0FFFFF;
	// Trap sources: bit set where a trap vector is connected
	localparam logic [7:0]  TrapLive           = 8'h3E;
	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0]  PendingFlagsAddr   = 8'h00;
	localparam logic [7:0]  LookupSelectAddr   = 8'h04;
	localparam logic [7:0]  LookupResultAddr   = 8'h08;
	localparam logic [15:0] PendingFlagsReset  = 16'h0000;
	localparam logic [15:0] PendingFlagsMask   = 16'hFFFB;
	localparam logic [1:0]  RespOkay           = 2'h0;
	localparam logic [1:0]  RespSlvErr         = 2'h2;
	// Lookup select fields
	localparam int          SelVecLsb          = 0;
	localparam int          SelTrapBit         = 8;
	localparam int          SelAltBit          = 9;
endpackage : vector_map_pkg
